/* logic/rcs_pkg.sv */
// Package of constants and carrier types for the clock control and status unit
package rcs_pkg;

    // ------------------------------------------------------------
    // Addresses and field positions
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL     = 4'h0;
    localparam logic [3:0] ADDR_SETTING     = 4'hF;
    localparam int         CTL_TEST_BIT     = 3;
    localparam int         CTL_CLK_STOP_BIT = 2;
    localparam int         CTL_INT_SEL_BIT  = 1;
    localparam int         CTL_INT_STOP_BIT = 0;
    localparam int         STS_CHANGED_BIT  = 3;
    localparam int         STS_INT_BIT      = 0;
    localparam int         SET_HOURS24_BIT  = 0;
    localparam int         SET_PM_BIT       = 1;
    localparam int         SET_LEAP_LSB     = 2;
    localparam int         INT_REPEAT_BIT   = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CTL_RESET        = 4'h5;
    localparam logic [3:0] SETTING_RESET    = 4'h0;
    localparam logic [3:0] INTREG_RESET     = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         OSC_HZ           = 32768;
    localparam int         TENTH_MS         = 100;
    localparam int         OSC_PER_TENTH    = OSC_HZ * TENTH_MS / 1000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       osc;
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] addr;
        logic [3:0] data;
    } rcs_pins_type;

    // Delay select code to timeout length in tenths of a second
    function automatic logic [9:0] delay_tenths(input logic [2:0] sel);
        case (sel)
            3'h1:    delay_tenths = 10'h001;
            3'h2:    delay_tenths = 10'h005;
            3'h3:    delay_tenths = 10'h00A;
            3'h4:    delay_tenths = 10'h032;
            3'h5:    delay_tenths = 10'h064;
            3'h6:    delay_tenths = 10'h12C;
            3'h7:    delay_tenths = 10'h258;
            default: delay_tenths = 10'h000;
        endcase
    endfunction : delay_tenths

endpackage : rcs_pkg

/* logic/rcs_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rcs_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rcs_sync_state_type;

    rcs_sync_state_type state_q;
    rcs_sync_state_type state_d;

    always_comb begin
        state_d        = state_q;
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    // Pins idle high, so reset to all ones avoids a false strobe edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;

endmodule : rcs_sync

/* logic/rcs_int_timer.sv */
// Interrupt delay timer counting oscillator ticks into tenths
`timescale 1ns/1ps
module rcs_int_timer #(
    parameter int PRE_COUNT = rcs_pkg::OSC_PER_TENTH
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       osc_tick,
    input  wire logic       run,
    input  wire logic       fast,
    input  wire logic [2:0] delay_sel,
    output logic            timeout
);

    typedef struct packed {
        logic [11:0] pre;
        logic [9:0]  cnt;
        logic        timeout;
    } rcs_timer_state_type;

    rcs_timer_state_type state_q;
    rcs_timer_state_type state_d;
    logic [9:0]          limit;

    always_comb begin
        limit           = rcs_pkg::delay_tenths(delay_sel);
        state_d         = state_q;
        state_d.timeout = 1'b0;
        if (!run) begin
            state_d.pre = '0;
            state_d.cnt = '0;
        end else if (osc_tick) begin
            if (fast || state_q.pre == 12'(PRE_COUNT - 1)) begin
                state_d.pre = '0;
                if (limit != 10'h000 && state_q.cnt + 10'h001 >= limit) begin
                    state_d.cnt     = '0;
                    state_d.timeout = 1'b1;
                end else begin
                    state_d.cnt = state_q.cnt + 10'h001;
                end
            end else begin
                state_d.pre = state_q.pre + 12'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign timeout = state_q.timeout;

endmodule : rcs_int_timer

/* logic/rcs_control_status.sv */
// Control, status and register select logic of the calendar clock
`timescale 1ns/1ps
module rcs_control_status #(
    parameter int PRE_COUNT = rcs_pkg::OSC_PER_TENTH
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       osc_in,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [3:0] addr,
    input  wire logic [3:0] data_in,
    output logic      [3:0] data_out,
    output logic            data_oe,
    output logic            irq_out,
    output logic            irq_oe,
    output logic            clock_set_pulse,
    output logic            clear_tenths,
    output logic            hours_24,
    output logic            pm_flag,
    output logic      [1:0] leap_count,
    input  wire logic       pm_toggle,
    input  wire logic       year_rollover
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        osc_prev;
        logic [11:0] prescale;
        logic        set_pulse;
        logic [3:0]  ctl;
        logic [3:0]  setting;
        logic [3:0]  intreg;
        logic        changed;
        logic        int_flag;
        logic        int_pending;
        logic        ctl_rd_prev;
        logic        wr_prev;
        logic [3:0]  wr_addr;
        logic [3:0]  wr_data;
        logic [3:0]  snap;
        logic [3:0]  dout;
        logic        doe;
        logic        irq_o;
        logic        irq_e;
    } rcs_main_state_type;

    rcs_main_state_type   state_q;
    rcs_main_state_type   state_d;
    rcs_pkg::rcs_pins_type pins_async;
    rcs_pkg::rcs_pins_type pins;
    logic                 osc_tick;
    logic                 rd_act;
    logic                 wr_act;
    logic                 ctl_rd;
    logic                 ctl_rd_end;
    logic                 wr_end;
    logic                 timeout;
    logic                 int_run;
    logic [3:0]           fresh;
    logic [3:0]           wv;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    assign pins_async = '{osc: osc_in, cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                          addr: addr, data: data_in};

    // Strobes and the oscillator are all asynchronous to sys_clk
    rcs_sync #(
        .W ($bits(rcs_pkg::rcs_pins_type))
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (pins_async),
        .sync_out (pins)
    );

    assign osc_tick   = pins.osc && !state_q.osc_prev;
    assign rd_act     = !pins.cs_n && !pins.rd_n;
    assign wr_act     = !pins.cs_n && !pins.wr_n;
    assign ctl_rd     = rd_act && pins.addr == rcs_pkg::ADDR_CONTROL;
    assign ctl_rd_end = state_q.ctl_rd_prev && !ctl_rd;
    assign wr_end     = state_q.wr_prev && !wr_act;
    assign int_run    = !state_q.ctl[rcs_pkg::CTL_INT_STOP_BIT];

    // ------------------------------------------------------------
    // Interrupt timer
    // ------------------------------------------------------------
    rcs_int_timer #(
        .PRE_COUNT (PRE_COUNT)
    ) u_timer (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .osc_tick  (osc_tick),
        .run       (int_run),
        .fast      (state_q.ctl[rcs_pkg::CTL_TEST_BIT]),
        .delay_sel (state_q.intreg[2:0]),
        .timeout   (timeout)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d             = state_q;
        state_d.osc_prev    = pins.osc;
        state_d.set_pulse   = 1'b0;
        state_d.ctl_rd_prev = ctl_rd;
        state_d.wr_prev     = wr_act;
        wv                  = state_q.wr_data;
        fresh               = {state_q.changed, 2'b00, state_q.int_flag};

        // Tenths prescaler, runs whatever register sits at 15
        if (state_q.ctl[rcs_pkg::CTL_CLK_STOP_BIT]) begin
            state_d.prescale = '0;
        end else if (osc_tick) begin
            if (state_q.ctl[rcs_pkg::CTL_TEST_BIT]) begin
                state_d.set_pulse = 1'b1;
            end else if (state_q.prescale == 12'(PRE_COUNT - 1)) begin
                state_d.prescale  = '0;
                state_d.set_pulse = 1'b1;
            end else begin
                state_d.prescale = state_q.prescale + 12'h001;
            end
        end

        // Capture address and data while the write strobe is low
        if (wr_act) begin
            state_d.wr_addr = pins.addr;
            state_d.wr_data = pins.data;
        end

        // Commit on the trailing edge of the write strobe
        if (wr_end) begin
            if (state_q.wr_addr == rcs_pkg::ADDR_CONTROL) begin
                state_d.ctl = wv;
            end else if (state_q.wr_addr == rcs_pkg::ADDR_SETTING) begin
                if (state_q.ctl[rcs_pkg::CTL_INT_SEL_BIT]) begin
                    state_d.intreg = wv;
                end else begin
                    state_d.setting = wv;
                end
            end
        end

        // Counter side effects on the setting register
        if (pm_toggle && !state_d.setting[rcs_pkg::SET_HOURS24_BIT]) begin
            state_d.setting[rcs_pkg::SET_PM_BIT] = !state_d.setting[rcs_pkg::SET_PM_BIT];
        end
        if (year_rollover) begin
            state_d.setting[3:2] = state_d.setting[3:2] + 2'b01;
        end
        if (state_d.setting[rcs_pkg::SET_HOURS24_BIT]) begin
            state_d.setting[rcs_pkg::SET_PM_BIT] = 1'b0;
        end

        // Single mode halts itself; zero word holds the timer stopped
        if (timeout && !state_q.intreg[rcs_pkg::INT_REPEAT_BIT]) begin
            state_d.ctl[rcs_pkg::CTL_INT_STOP_BIT] = 1'b1;
        end
        if (state_d.intreg == 4'h0) begin
            state_d.ctl[rcs_pkg::CTL_INT_STOP_BIT] = 1'b1;
        end

        // Status flags around a control read
        if (ctl_rd && !state_q.ctl_rd_prev) begin
            state_d.snap = fresh;
        end
        if (ctl_rd) begin
            if (timeout) begin
                state_d.int_pending = 1'b1;
            end
        end else if (ctl_rd_end) begin
            // Events in the closing cycle win over the clear
            state_d.changed     = state_q.set_pulse;
            state_d.int_flag    = state_q.int_pending || timeout;
            state_d.int_pending = 1'b0;
        end else begin
            if (state_q.set_pulse) begin
                state_d.changed = 1'b1;
            end
            if (timeout) begin
                state_d.int_flag = 1'b1;
            end
        end
        // Setting pulses inside the read are dropped on purpose; timeouts are held in int_pending
        if (ctl_rd && state_q.ctl_rd_prev) begin
            state_d.changed = state_q.changed;
        end

        // Read data path
        state_d.doe  = rd_act && (pins.addr == rcs_pkg::ADDR_CONTROL ||
                                  pins.addr == rcs_pkg::ADDR_SETTING);
        state_d.dout = 4'h0;
        if (rd_act && pins.addr == rcs_pkg::ADDR_CONTROL) begin
            state_d.dout = state_q.ctl_rd_prev ? state_q.snap : fresh;
        end else if (rd_act && pins.addr == rcs_pkg::ADDR_SETTING) begin
            state_d.dout = state_q.ctl[rcs_pkg::CTL_INT_SEL_BIT] ?
                           state_q.intreg : state_q.setting;
        end

        // Interrupt pin: oscillator in bare test mode, else open drain
        if (state_q.ctl[rcs_pkg::CTL_TEST_BIT] && state_q.intreg == 4'h0) begin
            state_d.irq_o = pins.osc;
            state_d.irq_e = 1'b1;
        end else begin
            state_d.irq_o = 1'b0;
            state_d.irq_e = state_d.int_flag;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q          <= '0;
            state_q.osc_prev <= 1'b1;
            state_q.ctl      <= rcs_pkg::CTL_RESET;
            state_q.setting  <= rcs_pkg::SETTING_RESET;
            state_q.intreg   <= rcs_pkg::INTREG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out        = state_q.dout;
    assign data_oe         = state_q.doe;
    assign irq_out         = state_q.irq_o;
    assign irq_oe          = state_q.irq_e;
    assign clock_set_pulse = state_q.set_pulse;
    assign clear_tenths    = state_q.ctl[rcs_pkg::CTL_CLK_STOP_BIT];
    assign hours_24        = state_q.setting[rcs_pkg::SET_HOURS24_BIT];
    assign pm_flag         = state_q.setting[rcs_pkg::SET_PM_BIT];
    assign leap_count      = state_q.setting[3:2];

endmodule : rcs_control_status

/* verif/rcs_cs_sva.sv */
// Port assertions for the clock control and status unit
`timescale 1ns/1ps
module rcs_cs_sva (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [3:0] addr,
    input wire logic [3:0] data_out,
    input wire logic       data_oe,
    input wire logic       irq_oe,
    input wire logic       clock_set_pulse,
    input wire logic       clear_tenths,
    input wire logic       hours_24,
    input wire logic       pm_flag,
    input wire logic [1:0] leap_count,
    input wire logic       pm_toggle,
    input wire logic       year_rollover
);
    // ----
    // Helpers
    // ----
    logic       rd_ctl;
    logic [3:0] wr_age_q;
    logic [3:0] rd_run_q;
    assign rd_ctl = !cs_n && !rd_n && (addr == 4'h0);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_age_q <= 4'hF;
            rd_run_q <= 4'h0;
        end else begin
            wr_age_q <= (!cs_n && !wr_n) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
            rd_run_q <= !rd_ctl ? 4'h0 : rd_run_q + {3'h0, rd_run_q != 4'hF};
        end
    end
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Slack of six cycles covers the strobe synchroniser on entry
    sequence ctl_read_deep;
        rd_ctl && rd_run_q > 4'h6;
    endsequence
    sequence recent_write;
        wr_age_q < 4'h8;
    endsequence
    chk_oe_cause: assert property (data_oe |-> $past(!cs_n && !rd_n, 3)
        && ($past(addr, 3) inside {4'h0, 4'hF})) else $error("data driven without read");
    chk_status_zero: assert property (data_oe && $past(addr, 3) == 4'h0
        |-> data_out[2:1] == 2'h0) else $error("status bits 2:1 not zero");
    chk_status_hold: assert property (data_oe && $past(data_oe) && $past(addr, 4) == 4'h0
        |-> $stable(data_out)) else $error("status changed during read");
    chk_pm_forced: assert property (hours_24 |-> !pm_flag)
        else $error("pm set in 24 hour mode");
    chk_pulse_single: assert property (clock_set_pulse |=> !clock_set_pulse)
        else $error("setting pulse longer than one cycle");
    chk_stop_quiet: assert property (clear_tenths && $past(clear_tenths)
        |-> !clock_set_pulse) else $error("setting pulse while clock stopped");
    chk_stop_by_write: assert property ($changed(clear_tenths) |-> recent_write)
        else $error("clock run state changed without a write");
    chk_irq_after_read: assert property ($rose(irq_oe) |-> not ctl_read_deep)
        else $error("interrupt asserted inside a status read");
    chk_leap_step: assert property (year_rollover
        |=> leap_count == $past(leap_count) + 2'h1) else $error("leap count not stepped");
    chk_pm_toggle: assert property (pm_toggle && !hours_24
        |=> pm_flag != $past(pm_flag)) else $error("pm not toggled in 12 hour mode");
endmodule : rcs_cs_sva

bind rcs_control_status rcs_cs_sva u_sva (
    .sys_clk, .reset, .cs_n, .rd_n, .wr_n, .addr, .data_out, .data_oe, .irq_oe,
    .clock_set_pulse, .clear_tenths, .hours_24, .pm_flag, .leap_count, .pm_toggle,
    .year_rollover
);

/* verif/rcs_host_model.sv */
// Host processor model driving the strobe bus
`timescale 1ns/1ps
module rcs_host_model (
    input  wire logic       sys_clk,
    input  wire logic [3:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [3:0] addr,
    output logic      [3:0] data
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        data = 4'h0;
    end
    // Strobes held four cycles, past the two the synchroniser needs
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(negedge sys_clk);
        addr = a;
        data = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
        data = ~d;
        repeat (4) @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input int hold, output logic [3:0] q,
                      output logic seen);
        q = 4'h0;
        seen = 1'b0;
        @(negedge sys_clk);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (hold) begin
            @(posedge sys_clk);
            if (data_oe === 1'b1 && !seen) begin
                q = data_out;
                seen = 1'b1;
            end
        end
        @(negedge sys_clk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : rd
endmodule : rcs_host_model

/* verif/rcs_control_status_tb.sv */
// Self-checking testbench for the clock control and status unit
`timescale 1ns/1ps
module rcs_control_status_tb;
    logic       sys_clk, reset, osc, pm_toggle, year_rollover, hit;
    logic       cs_n, rd_n, wr_n, data_oe, irq_out, irq_oe, seen;
    logic       clock_set_pulse, clear_tenths, hours_24, pm_flag;
    logic [3:0] addr, data_in, data_out, q;
    logic [1:0] leap_count;
    int         bad_count, compares;
    // Open-drain pin with pull-up: low only while driven low
    wire        irq_low = (irq_oe === 1'b1) && (irq_out === 1'b0);

    rcs_control_status #(.PRE_COUNT(4)) dut (
        .sys_clk, .reset, .osc_in(osc), .cs_n, .rd_n, .wr_n, .addr, .data_in,
        .data_out, .data_oe, .irq_out, .irq_oe, .clock_set_pulse, .clear_tenths,
        .hours_24, .pm_flag, .leap_count, .pm_toggle, .year_rollover
    );
    rcs_host_model u_host (
        .sys_clk, .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .addr, .data(data_in)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Oscillator far faster than real so the run stays short
    initial begin
        osc = 1'b0;
        forever begin
            repeat (8) @(negedge sys_clk);
            osc = ~osc;
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input string name, input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rdc(input logic [3:0] a, input logic [3:0] exp, input string name);
        logic [3:0] v;
        logic       s;
        u_host.rd(a, 8, v, s);
        chk({name, "_oe"}, 4'(s), 4'h1);
        chk(name, v, exp);
    endtask : rdc
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : pulse
    task automatic wait_ev(input logic on_irq, input int n, output logic h);
        h = 1'b0;
        for (int i = 0; i < n && !h; i++) begin
            @(posedge sys_clk);
            h = on_irq ? irq_low : (clock_set_pulse === 1'b1);
        end
    endtask : wait_ev
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        chk("clear_tenths", 4'(clear_tenths), 4'h1);
        chk("leap", 4'(leap_count), 4'h0);
        rdc(4'h0, 4'h0, "status");
        rdc(4'hF, 4'h0, "setting");
        u_host.rd(4'h5, 8, q, seen);
        chk("oe_unmapped", 4'(seen), 4'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_init;
        int   edges;
        logic prev;
        u_host.wr(4'h0, 4'hF);
        u_host.wr(4'hF, 4'h0);
        edges = 0;
        prev = irq_out;
        repeat (40) begin
            @(posedge sys_clk);
            if (irq_oe === 1'b1 && irq_out !== prev) edges++;
            prev = irq_out;
        end
        chk("osc_on_irq", 4'(edges > 2), 4'h1);
        u_host.wr(4'h0, 4'h5);
        chk("irq_oe_normal", 4'(irq_oe), 4'h0);
        u_host.wr(4'hF, 4'h8);
        pulse(pm_toggle);
        pulse(year_rollover);
        rdc(4'hF, 4'hE, "setting");
        u_host.wr(4'hF, 4'h1);
        chk("hours_24", 4'(hours_24), 4'h1);
        pulse(pm_toggle);
        chk("pm_24h", 4'(pm_flag), 4'h0);
        rdc(4'hF, 4'h1, "setting");
        $display("t_init done");
    endtask : t_init
    task automatic t_changed;
        u_host.wr(4'h0, 4'h0);
        chk("clear_tenths", 4'(clear_tenths), 4'h0);
        wait_ev(1'b0, 200, hit);
        chk("set_pulse", 4'(hit), 4'h1);
        // Aligned to a setting pulse: the long read below spans the next one
        rdc(4'h0, 4'h8, "status");
        u_host.rd(4'h0, 80, q, seen);
        chk("status_latched", q, 4'h0);
        rdc(4'h0, 4'h0, "status");
        wait_ev(1'b0, 200, hit);
        chk("set_pulse", 4'(hit), 4'h1);
        u_host.wr(4'h0, 4'h4);
        chk("clear_tenths", 4'(clear_tenths), 4'h1);
        u_host.wr(4'hF, 4'h1);
        rdc(4'hF, 4'h1, "setting");
        rdc(4'h0, 4'h8, "status");
        rdc(4'h0, 4'h0, "status");
        $display("t_changed done");
    endtask : t_changed
    task automatic t_single;
        u_host.wr(4'h0, 4'h6);
        u_host.wr(4'hF, 4'h1);
        wait_ev(1'b1, 300, hit);
        chk("irq_held", 4'(hit), 4'h0);
        u_host.wr(4'h0, 4'h6);
        wait_ev(1'b1, 200, hit);
        chk("irq_timeout", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        chk("irq_released", 4'(irq_low), 4'h0);
        wait_ev(1'b1, 300, hit);
        chk("single_stop", 4'(hit), 4'h0);
        u_host.wr(4'h0, 4'h6);
        wait_ev(1'b1, 200, hit);
        chk("single_again", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        $display("t_single done");
    endtask : t_single
    task automatic t_repeat;
        u_host.wr(4'h0, 4'h7);
        u_host.wr(4'hF, 4'h9);
        u_host.wr(4'h0, 4'h6);
        wait_ev(1'b1, 200, hit);
        chk("repeat_first", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        wait_ev(1'b1, 200, hit);
        chk("repeat_next", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        u_host.rd(4'h0, 150, q, seen);
        chk("status_long", q, 4'h0);
        wait_ev(1'b1, 12, hit);
        chk("irq_after_read", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        u_host.wr(4'h0, 4'h7);
        u_host.rd(4'h0, 8, q, seen);
        wait_ev(1'b1, 300, hit);
        chk("repeat_stopped", 4'(hit), 4'h0);
        $display("t_repeat done");
    endtask : t_repeat
    task automatic t_test;
        u_host.wr(4'h0, 4'hE);
        wait_ev(1'b1, 100, hit);
        chk("fast_timeout", 4'(hit), 4'h1);
        rdc(4'h0, 4'h1, "status");
        u_host.wr(4'h0, 4'hF);
        wait_ev(1'b0, 100, hit);
        chk("fast_gated", 4'(hit), 4'h0);
        u_host.wr(4'h0, 4'hB);
        wait_ev(1'b0, 40, hit);
        chk("fast_clocking", 4'(hit), 4'h1);
        u_host.wr(4'h0, 4'h5);
        $display("t_test done");
    endtask : t_test
    // ----
    // Run
    // ----
    initial begin
        reset = 1'b1;
        pm_toggle = 1'b0;
        year_rollover = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_reset;
        t_init;
        t_changed;
        t_single;
        t_repeat;
        t_test;
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_of_test;
    end
endmodule : rcs_control_status_tb
